// *** core/ahb_ctl_defines.svh ***
// timing and layout constants for the converter bus control
`ifndef AHB_CTL_DEFINES_SVH
`define AHB_CTL_DEFINES_SVH
`define AHB_CLK_MHZ          250
`define AHB_FAST_T12_NS      9000
`define AHB_FAST_T8_NS       6800
`define AHB_SLOW_T12_NS      11000
`define AHB_SLOW_T8_NS       8300
`define AHB_RES_W            12
`define AHB_CNT_W            16
`define AHB_CNT_ONE          16'h0001
`define AHB_CNT_ZERO         16'h0000
`define AHB_RES_ZERO         12'h000
`define AHB_HI_NIB_MSB       11
`define AHB_HI_NIB_LSB       8
`define AHB_LO_BYTE_MSB      7
`define AHB_LO_BYTE_LSB      0
`define AHB_SHORT_MASK       12'hFF0
`define AHB_NS_PER_US        1000
`define AHB_SYNC_FIRST       0
`define AHB_SYNC_MID         1
`define AHB_SYNC_LAST        2
`define AHB_SYNC_IDLE_LO     3'h0
`define AHB_SYNC_IDLE_HI     3'h7
`define AHB_LVL_LO           1'b0
`define AHB_LVL_HI           1'b1
`define AHB_UPPER_LSB        4
`define AHB_LO_NIB_MSB       3
`endif

// *** core/ahb_ctl_pkg.sv ***
// types for the converter bus control
package ahb_ctl_pkg;
    typedef enum logic [1:0] {AHB_IDLE, AHB_CONV} ahb_state_t;
    typedef logic [11:0] ahb_word_t;
endpackage

// *** core/ahb_ctl.sv ***
// converter host bus control: start, busy status and result bus
`timescale 1ns/1ns
`include "ahb_ctl_defines.svh"
// Operation
// - width select high gives 12-bit parallel output, low gives byte-wise 8-bit output
// - select high makes the device ignore all bus activity
// - chip enable low disables; requests only with enable high and select low
// - busy output stays high throughout a conversion, low otherwise
// - fast grade: 12-bit within 9 us, 8-bit within 6.8 us
// - slow grade: 12-bit within 11 us, 8-bit within 8.3 us
// - result left-justified, unsigned fraction 0 to 4095/4096 of full scale
module ahb_ctl
(
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 nrst,
    input  wire logic                 clk_en,
    // host bus pins
    input  wire logic                 chip_enable,
    input  wire logic                 chip_select_n,
    input  wire logic                 read_convert,
    input  wire logic                 byte_addr_short_cycle,
    input  wire logic                 width_12_sel,
    // speed grade strap, high selects the slower grade
    input  wire logic                 slow_grade,
    // comparator result from the analog core
    input  wire ahb_ctl_pkg::ahb_word_t sample_code,
    // result bus and status
    output logic [`AHB_RES_W-1:0]     result_out,
    output logic [`AHB_RES_W-1:0]     result_oe_n,
    output logic                      conversion_busy
);
    import ahb_ctl_pkg::*;

    localparam logic [`AHB_CNT_W-1:0] CYC_FAST12 = `AHB_CNT_W'((`AHB_FAST_T12_NS * `AHB_CLK_MHZ) / `AHB_NS_PER_US);
    localparam logic [`AHB_CNT_W-1:0] CYC_FAST8  = `AHB_CNT_W'((`AHB_FAST_T8_NS * `AHB_CLK_MHZ) / `AHB_NS_PER_US);
    localparam logic [`AHB_CNT_W-1:0] CYC_SLOW12 = `AHB_CNT_W'((`AHB_SLOW_T12_NS * `AHB_CLK_MHZ) / `AHB_NS_PER_US);
    localparam logic [`AHB_CNT_W-1:0] CYC_SLOW8  = `AHB_CNT_W'((`AHB_SLOW_T8_NS * `AHB_CLK_MHZ) / `AHB_NS_PER_US);

    // three-stage pin synchronisers
    logic [2:0] ce_s_reg;
    logic [2:0] cs_s_reg;
    logic [2:0] rc_s_reg;
    logic [2:0] ao_s_reg;
    logic [2:0] w_s_reg;
    logic [2:0] sg_s_reg;
    logic [2:0] ce_s_next;
    logic [2:0] cs_s_next;
    logic [2:0] rc_s_next;
    logic [2:0] ao_s_next;
    logic [2:0] w_s_next;
    logic [2:0] sg_s_next;
    logic       ce_reg;
    logic       cs_n_reg;
    logic       rc_reg;
    logic       ao_reg;
    logic       w12_reg;
    logic       sg_reg;
    logic       ce_next;
    logic       cs_n_next;
    logic       rc_next;
    logic       ao_next;
    logic       w12_next;
    logic       sg_next;

    function automatic logic settle(input logic [2:0] s, input logic cur);
        settle = (s[`AHB_SYNC_MID] == s[`AHB_SYNC_LAST]) ? s[`AHB_SYNC_LAST] : cur;
    endfunction

    function automatic logic [`AHB_CNT_W-1:0] conv_len(input logic slow, input logic short_c);
        case ({slow, short_c})
            2'b00:   conv_len = CYC_FAST12;
            2'b01:   conv_len = CYC_FAST8;
            2'b10:   conv_len = CYC_SLOW12;
            default: conv_len = CYC_SLOW8;
        endcase
    endfunction

    always_comb
    begin
        ce_s_next = {ce_s_reg[`AHB_SYNC_MID:`AHB_SYNC_FIRST], chip_enable};
        cs_s_next = {cs_s_reg[`AHB_SYNC_MID:`AHB_SYNC_FIRST], chip_select_n};
        rc_s_next = {rc_s_reg[`AHB_SYNC_MID:`AHB_SYNC_FIRST], read_convert};
        ao_s_next = {ao_s_reg[`AHB_SYNC_MID:`AHB_SYNC_FIRST], byte_addr_short_cycle};
        w_s_next  = {w_s_reg[`AHB_SYNC_MID:`AHB_SYNC_FIRST], width_12_sel};
        sg_s_next = {sg_s_reg[`AHB_SYNC_MID:`AHB_SYNC_FIRST], slow_grade};
        ce_next   = settle(ce_s_reg, ce_reg);
        cs_n_next = settle(cs_s_reg, cs_n_reg);
        rc_next   = settle(rc_s_reg, rc_reg);
        ao_next   = settle(ao_s_reg, ao_reg);
        w12_next  = settle(w_s_reg, w12_reg);
        sg_next   = settle(sg_s_reg, sg_reg);
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            ce_s_reg <= `AHB_SYNC_IDLE_LO;
            cs_s_reg <= `AHB_SYNC_IDLE_HI;
            rc_s_reg <= `AHB_SYNC_IDLE_HI;
            ao_s_reg <= `AHB_SYNC_IDLE_LO;
            w_s_reg  <= `AHB_SYNC_IDLE_HI;
            sg_s_reg <= `AHB_SYNC_IDLE_LO;
            ce_reg   <= `AHB_LVL_LO;
            cs_n_reg <= `AHB_LVL_HI;
            rc_reg   <= `AHB_LVL_HI;
            ao_reg   <= `AHB_LVL_LO;
            w12_reg  <= `AHB_LVL_HI;
            sg_reg   <= `AHB_LVL_LO;
        end
        else if (clk_en)
        begin
            ce_s_reg <= ce_s_next;
            cs_s_reg <= cs_s_next;
            rc_s_reg <= rc_s_next;
            ao_s_reg <= ao_s_next;
            w_s_reg  <= w_s_next;
            sg_s_reg <= sg_s_next;
            ce_reg   <= ce_next;
            cs_n_reg <= cs_n_next;
            rc_reg   <= rc_next;
            ao_reg   <= ao_next;
            w12_reg  <= w12_next;
            sg_reg   <= sg_next;
        end
    end

    // conversion control
    ahb_state_t                  state_reg, state_next;
    logic [`AHB_CNT_W-1:0]       cnt_reg, cnt_next;
    logic                        short_reg, short_next;
    ahb_word_t                   data_reg, data_next;
    logic                        access, start_req, prev_start_reg, prev_start_next;
    logic [`AHB_RES_W-1:0]       out_next, oe_n_next;
    logic                        busy_next;

    assign access    = ce_reg && !cs_n_reg;
    assign start_req = access && !rc_reg;

    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        short_next = short_reg;
        data_next  = data_reg;
        prev_start_next = start_req;
        case (state_reg)
            AHB_IDLE:
            begin
                // a held start level begins only one conversion
                if (start_req && !prev_start_reg)
                begin
                    state_next = AHB_CONV;
                    short_next = ao_reg;
                    cnt_next   = conv_len(sg_reg, ao_reg);
                end
            end
            AHB_CONV:
            begin
                if (cnt_reg <= `AHB_CNT_ONE)
                begin
                    state_next = AHB_IDLE;
                    cnt_next   = `AHB_CNT_ZERO;
                    // left-justified; short cycle clears the low nibble
                    data_next  = short_reg ? (sample_code & `AHB_SHORT_MASK) : sample_code;
                end
                else
                    cnt_next = cnt_reg - `AHB_CNT_ONE;
            end
            default: state_next = AHB_IDLE;
        endcase
        busy_next = (state_next == AHB_CONV);
        // read enables the bus only while idle
        out_next  = `AHB_RES_ZERO;
        oe_n_next = {`AHB_RES_W{1'b1}};
        if (access && rc_reg && state_reg == AHB_IDLE)
        begin
            if (w12_reg)
            begin
                out_next  = data_reg;
                oe_n_next = `AHB_RES_ZERO;
            end
            else if (!ao_reg)
            begin
                out_next[`AHB_LO_BYTE_MSB:`AHB_LO_BYTE_LSB] = data_reg[`AHB_HI_NIB_MSB:`AHB_UPPER_LSB];
                oe_n_next[`AHB_LO_BYTE_MSB:`AHB_LO_BYTE_LSB] = 8'h00;
            end
            else
            begin
                out_next[`AHB_HI_NIB_MSB:`AHB_HI_NIB_LSB] = data_reg[`AHB_LO_NIB_MSB:`AHB_LO_BYTE_LSB];
                oe_n_next[`AHB_HI_NIB_MSB:`AHB_HI_NIB_LSB] = 4'h0;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            state_reg       <= AHB_IDLE;
            cnt_reg         <= `AHB_CNT_ZERO;
            short_reg       <= `AHB_LVL_LO;
            data_reg        <= `AHB_RES_ZERO;
            prev_start_reg  <= `AHB_LVL_LO;
            result_out      <= `AHB_RES_ZERO;
            result_oe_n     <= {`AHB_RES_W{1'b1}};
            conversion_busy <= `AHB_LVL_LO;
        end
        else if (clk_en)
        begin
            state_reg       <= state_next;
            cnt_reg         <= cnt_next;
            short_reg       <= short_next;
            data_reg        <= data_next;
            prev_start_reg  <= prev_start_next;
            result_out      <= out_next;
            result_oe_n     <= oe_n_next;
            conversion_busy <= busy_next;
        end
    end
endmodule

// *** verification/ahb_ctl_asserts.sv ***
// port assertions for the converter bus control
`timescale 1ns/1ns
module ahb_ctl_asserts
(
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        nrst,
    // host pins
    input wire logic        chip_enable,
    input wire logic        chip_select_n,
    input wire logic        read_convert,
    input wire logic        width_12_sel,
    // device outputs
    input wire logic [11:0] result_out,
    input wire logic [11:0] result_oe_n,
    input wire logic        conversion_busy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    property p_start; $rose(conversion_busy) |->
        !$past(chip_select_n, 3) && $past(chip_enable, 3) && !$past(read_convert, 3); endproperty
    a_start: assert property (p_start) else $error("busy rose without a start");
    property p_min; $rose(conversion_busy) |-> conversion_busy[*8]; endproperty
    a_min: assert property (p_min) else $error("busy dropped early");
    property p_off; conversion_busy |-> &result_oe_n; endproperty
    a_off: assert property (p_off) else $error("bus driven while busy");
    property p_oe; result_oe_n inside {12'hFFF, 12'h000, 12'hF00, 12'h0FF}; endproperty
    a_oe: assert property (p_oe) else $error("illegal enable pattern");
    property p_zero; (result_out & result_oe_n) == 12'h000; endproperty
    a_zero: assert property (p_zero) else $error("undriven bit not zero");
    property p_cs; chip_select_n[*8] |-> &result_oe_n; endproperty
    a_cs: assert property (p_cs) else $error("bus on while deselected");
    property p_ce; !chip_enable[*8] |-> &result_oe_n; endproperty
    a_ce: assert property (p_ce) else $error("bus on while disabled");
    property p_w8; !width_12_sel[*8] |-> result_oe_n != 12'h000; endproperty
    a_w8: assert property (p_w8) else $error("full drive in byte mode");
endmodule
bind ahb_ctl ahb_ctl_asserts ahb_ctl_asserts_inst (.ref_clk(ref_clk), .nrst(nrst), .chip_enable(chip_enable),
    .chip_select_n(chip_select_n), .read_convert(read_convert), .width_12_sel(width_12_sel),
    .result_out(result_out), .result_oe_n(result_oe_n), .conversion_busy(conversion_busy));

// *** verification/ahb_host.sv ***
// host bus model driving the converter pins
`timescale 1ns/1ns
module ahb_host
(
    // clock
    input  wire logic ref_clk,
    // host bus pins
    output logic      chip_enable,
    output logic      chip_select_n,
    output logic      read_convert,
    output logic      byte_addr_short_cycle
);
    initial
    begin
        chip_enable = 1'b0;
        chip_select_n = 1'b1;
        read_convert = 1'b1;
        byte_addr_short_cycle = 1'b0;
    end
    // one access held for eight cycles, then released
    task automatic access(input logic ce, input logic cs_n, input logic rc, input logic ao);
        @(posedge ref_clk);
        chip_enable <= ce;
        chip_select_n <= cs_n;
        read_convert <= rc;
        byte_addr_short_cycle <= ao;
        repeat (8) @(posedge ref_clk);
        chip_enable <= 1'b0;
        chip_select_n <= 1'b1;
        read_convert <= 1'b1;
    endtask
endmodule

// *** verification/ahb_ctl_tb.sv ***
// self-checking bench for the converter bus control
`timescale 1ns/1ns
module ahb_ctl_tb;
    import ahb_ctl_pkg::*;
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        width_12_sel = 1'b1;
    logic        slow_grade = 1'b0;
    ahb_word_t   sample_code = 12'h000;
    logic        clk_en = 1'b1;
    logic        ce, cs_n, rc, ao, conversion_busy;
    logic [11:0] result_out, result_oe_n;
    logic [11:0] busy_cnt = 12'h000;
    int          n_errors = 0;
    int          checks = 0;
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (conversion_busy === 1'b1) busy_cnt <= busy_cnt + 12'h001;
    ahb_host ahb_host_inst (.ref_clk(ref_clk), .chip_enable(ce), .chip_select_n(cs_n), .read_convert(rc),
        .byte_addr_short_cycle(ao));
    ahb_ctl ahb_ctl_inst (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .chip_enable(ce),
        .chip_select_n(cs_n), .read_convert(rc), .byte_addr_short_cycle(ao), .width_12_sel(width_12_sel),
        .slow_grade(slow_grade), .sample_code(sample_code), .result_out(result_out),
        .result_oe_n(result_oe_n), .conversion_busy(conversion_busy));
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        if (n_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic refuse();
        logic [11:0] base;
        base = busy_cnt;
        ahb_host_inst.access(1'b1, 1'b1, 1'b0, 1'b0);
        ahb_host_inst.access(1'b0, 1'b0, 1'b0, 1'b0);
        ahb_host_inst.access(1'b1, 1'b1, 1'b1, 1'b0);
        #1 check(result_oe_n, 12'hFFF);
        ahb_host_inst.access(1'b0, 1'b0, 1'b1, 1'b0);
        #1 check(result_oe_n, 12'hFFF);
        repeat (8) @(posedge ref_clk);
        #1 check(busy_cnt - base, 12'h000);
    endtask
    // reset in mid-conversion clears busy and floats the bus
    task automatic mid_reset();
        logic [11:0] base;
        ahb_host_inst.access(1'b1, 1'b0, 1'b0, 1'b0);
        check({11'h000, conversion_busy}, 12'h001);
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 check({11'h000, conversion_busy}, 12'h000);
        check(result_oe_n, 12'hFFF);
        check(result_out, 12'h000);
        @(posedge ref_clk);
        nrst <= 1'b1;
        base = busy_cnt;
        repeat (12) @(posedge ref_clk);
        #1 check(busy_cnt - base, 12'h000);
    endtask
    task automatic conv_read(input logic slow, input logic ao_in, input logic [11:0] len,
        input logic [11:0] hold, input ahb_word_t code);
        ahb_word_t   e;
        logic [11:0] base;
        e = ao_in ? (code & 12'hFF0) : code;
        @(posedge ref_clk);
        slow_grade <= slow;
        sample_code <= code;
        width_12_sel <= 1'b1;
        base = busy_cnt;
        ahb_host_inst.access(1'b1, 1'b0, 1'b0, ao_in);
        // frozen cycles stretch busy by exactly their number
        if (hold != 12'h000)
        begin
            clk_en <= 1'b0;
            repeat (hold) @(posedge ref_clk);
            clk_en <= 1'b1;
        end
        for (int i = 0; i < 3000 && conversion_busy !== 1'b0; i++)
            @(posedge ref_clk);
        #1 check(busy_cnt - base, len + hold);
        ahb_host_inst.access(1'b1, 1'b0, 1'b1, 1'b0);
        #1 check(result_out, e);
        check(result_oe_n, 12'h000);
        @(posedge ref_clk);
        width_12_sel <= 1'b0;
        ahb_host_inst.access(1'b1, 1'b0, 1'b1, 1'b0);
        #1 check(result_out, {4'h0, e[11:4]});
        check(result_oe_n, 12'hF00);
        ahb_host_inst.access(1'b1, 1'b0, 1'b1, 1'b1);
        #1 check(result_out, {e[3:0], 8'h00});
        check(result_oe_n, 12'h0FF);
    endtask
    initial
    begin
        #200000;
        n_errors++;
        conclude();
    end
    initial
    begin
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        refuse();
        mid_reset();
        conv_read(1'b0, 1'b0, 12'h8CA, 12'h014, 12'hA5C);
        conv_read(1'b0, 1'b1, 12'h6A4, 12'h000, 12'h3E7);
        conv_read(1'b1, 1'b0, 12'hABE, 12'h000, 12'hFFF);
        conv_read(1'b1, 1'b1, 12'h81B, 12'h000, 12'h001);
        conclude();
    end
endmodule
